// ### rtl/pam_map.svh
// Constants of the port A pin multiplexer and processor clock output.
// Assumes inclusion by bare name from the package and the design modules.
//
// Contract
// - Clock pin carries the processor clock, locked to the crystal reference.
// - Boot byte bit 2 picks 24 MHz (zero) or 48 MHz (one).
// - Boot byte bit 1 set inverts the clock pin, otherwise straight.
// - Missing boot memory means an all-zero boot byte: 24 MHz, not inverted.
// - Processor control bit 1 set floats the clock pin.
// - Interface engine runs from fixed 48 MHz or external clock, rate-independent.
// - Bits 0-2 choose port or alternate from own select bit and interface bit 3.
// - Bit 3 chooses port or chip select from select bit 3 only.
// - Bit 4 chooses from both select bits 4 and interface mode field.
// - In port mode each pin drives, reads back or floats.
// - Timer 0 overflow pin pulses one clock-out cycle; mode 3 uses low byte.
// - Timer 1 overflow pin pulses one clock-out cycle; mode 3 uses low byte.
// - Bit 2 in memory function drives active-low memory output enable.
// - Bit 3 in memory function drives active-low memory chip select.
// - Bit 4 in FIFO function drives active-low external FIFO write strobe.
// - Bit 4 in ready mode passes the outside ready level to the engine.
// - Bit 4 in slave mode passes the outside write strobe to slave FIFOs.
// - After reset every pin is a port input; boards pull strobes high.
`ifndef PAM_MAP_SVH
`define PAM_MAP_SVH

// Clock rates in MHz
`define PAM_CLK_MHZ 40
`define PAM_XTAL_MHZ 12
`define PAM_PROC_SLOW_MHZ 24
`define PAM_PROC_FAST_MHZ 48
`define PAM_ENGINE_MHZ 48
`define PAM_SLOW_RATIO (`PAM_PROC_FAST_MHZ / `PAM_PROC_SLOW_MHZ)

// Boot byte, control and configuration fields
`define PAM_BOOT_RESET 8'h00
`define PAM_BOOT_RATE_BIT 2
`define PAM_BOOT_INV_BIT 1
`define PAM_CTRL_HIZ_BIT 1
`define PAM_IFC_ALT_BIT 3
`define PAM_IFC_MODE_HI 1
`define PAM_IFC_MODE_LO 0
`define PAM_IFC_MODE_ENGINE 2'h2
`define PAM_IFC_MODE_SLAVE 2'h3
`define PAM_TMR_SPLIT_MODE 2'h3

// Pin count and number of low bits gated by the interface bit
`define PAM_PA_BITS 5
`define PAM_ALT_LOW_BITS 3

`endif

// ### rtl/pam_pkg.sv
// Types of the port A pin multiplexer.
// Assumes the constants header is on the include path.
`include "pam_map.svh"

package pam_pkg;
	// Function chosen for port A bit 4
	typedef enum logic [1:0]
	{
		pam_pa4_port,
		pam_pa4_fifo_wr,
		pam_pa4_ready,
		pam_pa4_slave_wr
	} pam_pa4_fn_e;

	// Overflow pulse stretcher states
	typedef enum logic [1:0]
	{
		pam_pls_idle,
		pam_pls_armed,
		pam_pls_high
	} pam_pls_e;

	typedef logic [7:0] pam_byte_t;
endpackage

// ### rtl/pam_clkgen.sv
// Processor clock generator and clock output pin driver.
// Assumes a raw crystal reference pin and boot settings held by the caller.
`include "pam_map.svh"

module pam_clkgen
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Reference and settings
	input wire logic crystal_input,
	input wire logic rate_fast,
	input wire logic invert,
	input wire logic float_pin,
	// Processor clock
	output logic proc_level,
	output logic proc_rise,
	// Clock pin
	output logic pin_o,
	output logic pin_oe
);
	import pam_pkg::*;

	logic [2:0] xs_r;
	logic div_r;
	logic level_r;
	logic rise_r;
	logic pin_o_r;
	logic pin_oe_r;
	wire x_rise;
	wire level_nxt;

	assign x_rise = xs_r[1] & ~xs_r[2];
	// Slow rate halves the reference-derived clock
	assign level_nxt = rate_fast ? xs_r[1] : div_r;

	////////////////////////////////////////////////////////////////
	// Reference synchroniser and edge tracking
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			xs_r <= 3'h0;
		else
			xs_r <= {xs_r[1:0], crystal_input};
	end

	// Divider steps only on reference edges, so phase stays locked
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			div_r <= 1'b0;
		else if (x_rise)
			div_r <= ~div_r;
	end

	// Internal level and its rising edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			level_r <= 1'b0;
			rise_r <= 1'b0;
		end
		else
		begin
			level_r <= level_nxt;
			rise_r <= level_nxt & ~level_r;
		end
	end

	// Pin level and enable
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_o_r <= 1'b0;
			pin_oe_r <= 1'b0;
		end
		else
		begin
			pin_o_r <= level_nxt ^ invert;
			pin_oe_r <= ~float_pin;
		end
	end

	assign proc_level = level_r;
	assign proc_rise = rise_r;
	assign pin_o = pin_o_r;
	assign pin_oe = pin_oe_r;
endmodule

// ### rtl/pam_top.sv
// Port A bits 0 to 4 pin multiplexer with processor clock output.
// Assumes selection bytes come from registers on clk; pins come from outside.
`include "pam_map.svh"

module pam_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Crystal reference
	input wire logic crystal_input,
	// Boot configuration load
	input wire logic boot_load_done,
	input wire logic boot_memory_answered,
	input wire pam_pkg::pam_byte_t boot_configuration_byte,
	// Control and configuration
	input wire pam_pkg::pam_byte_t processor_control_status,
	input wire pam_pkg::pam_byte_t port_a_alt_select,
	input wire pam_pkg::pam_byte_t port_a_alt_select_second,
	input wire pam_pkg::pam_byte_t interface_configuration,
	input wire logic interface_clock_select,
	// Port data from the processor
	input wire logic [`PAM_PA_BITS-1:0] port_a_out,
	input wire logic [`PAM_PA_BITS-1:0] port_a_dir_out,
	// Timer overflow events
	input wire logic timer_zero_ovf_full,
	input wire logic timer_zero_ovf_low,
	input wire logic [1:0] timer_zero_mode,
	input wire logic timer_one_ovf_full,
	input wire logic timer_one_ovf_low,
	input wire logic [1:0] timer_one_mode,
	// Memory and FIFO strobes from the core
	input wire logic mem_output_enable_n,
	input wire logic mem_chip_select_n,
	input wire logic external_fifo_write_n,
	// Port A pins
	input wire logic [`PAM_PA_BITS-1:0] port_a_pin_i,
	output logic [`PAM_PA_BITS-1:0] port_a_pin_o,
	output logic [`PAM_PA_BITS-1:0] port_a_pin_oe,
	// Clock pin
	output logic processor_clock_pin_o,
	output logic processor_clock_pin_oe,
	// Processor clock status
	output logic proc_clock_level,
	output logic proc_clock_rise,
	output logic proc_rate_fast_r,
	output logic proc_clock_inverted_r,
	// Port readback and engine inputs
	output logic [`PAM_PA_BITS-1:0] port_a_in_r,
	output logic engine_ready_input_four_r,
	output logic slave_fifo_write_strobe_r,
	output logic engine_clock_external_r,
	// Timer pulses as driven
	output logic timer_zero_overflow_pulse_r,
	output logic timer_one_overflow_pulse_r
);
	import pam_pkg::*;

	////////////////////////////////////////////////////////////////
	// Decode helpers

	// Low bits take their alternate only while the interface bit is clear
	function automatic logic pam_alt_low(input logic sel, input logic ifc_bit);
		pam_alt_low = sel & ~ifc_bit;
	endfunction

	// Timer event seen on the overflow pin, by timer mode
	function automatic logic pam_tmr_evt
	(
		input logic full,
		input logic low,
		input logic [1:0] mode
	);
		pam_tmr_evt = (mode == `PAM_TMR_SPLIT_MODE) ? low : full;
	endfunction

	////////////////////////////////////////////////////////////////
	// Boot configuration byte

	pam_byte_t boot_r;
	wire pam_byte_t boot_nxt;

	// No answer from boot memory loads zero
	assign boot_nxt = boot_memory_answered ? boot_configuration_byte
		: `PAM_BOOT_RESET;

	// Taken once per load
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			boot_r <= `PAM_BOOT_RESET;
		else if (boot_load_done)
			boot_r <= boot_nxt;
	end

	wire rate_fast;
	wire clk_invert;
	wire clk_float;

	assign rate_fast = boot_r[`PAM_BOOT_RATE_BIT];
	assign clk_invert = boot_r[`PAM_BOOT_INV_BIT];
	assign clk_float = processor_control_status[`PAM_CTRL_HIZ_BIT];

	////////////////////////////////////////////////////////////////
	// Processor clock generator

	pam_clkgen u_clkgen
	(
		.clk(clk),
		.nrst(nrst),
		.crystal_input(crystal_input),
		.rate_fast(rate_fast),
		.invert(clk_invert),
		.float_pin(clk_float),
		.proc_level(proc_clock_level),
		.proc_rise(proc_clock_rise),
		.pin_o(processor_clock_pin_o),
		.pin_oe(processor_clock_pin_oe)
	);

	// Rate and inversion status
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			proc_rate_fast_r <= 1'b0;
			proc_clock_inverted_r <= 1'b0;
		end
		else
		begin
			proc_rate_fast_r <= rate_fast;
			proc_clock_inverted_r <= clk_invert;
		end
	end

	// Engine clock source, untouched by the processor rate
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			engine_clock_external_r <= 1'b0;
		else
			engine_clock_external_r <= interface_clock_select;
	end

	////////////////////////////////////////////////////////////////
	// Pin input synchroniser

	logic [`PAM_PA_BITS-1:0] pin_s1_r;
	logic [`PAM_PA_BITS-1:0] pin_s2_r;

	// Two stages before any logic reads a pin
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end
		else
		begin
			pin_s1_r <= port_a_pin_i;
			pin_s2_r <= pin_s1_r;
		end
	end

	assign port_a_in_r = pin_s2_r;

	////////////////////////////////////////////////////////////////
	// Timer overflow pulse stretchers

	wire [1:0] tmr_evt;
	wire [1:0] tmr_pulse;

	assign tmr_evt[0] = pam_tmr_evt(timer_zero_ovf_full, timer_zero_ovf_low,
		timer_zero_mode);
	assign tmr_evt[1] = pam_tmr_evt(timer_one_ovf_full, timer_one_ovf_low,
		timer_one_mode);

	// Pulse spans one whole clock-out period, rise to rise
	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1)
		begin : g_tmr
			pam_pls_e st_r;
			pam_pls_e st_nxt;
			logic pls_r;

			always_comb
			begin
				st_nxt = st_r;
				case (st_r)
					pam_pls_idle:
						if (tmr_evt[t])
							st_nxt = pam_pls_armed;
					pam_pls_armed:
						if (proc_clock_rise)
							st_nxt = pam_pls_high;
					pam_pls_high:
						if (proc_clock_rise)
							st_nxt = tmr_evt[t] ? pam_pls_armed : pam_pls_idle;
						else if (tmr_evt[t])
							st_nxt = pam_pls_high;
					default:
						st_nxt = pam_pls_idle;
				endcase
			end

			// State and its pulse flag, so the pin output leaves a flop
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					st_r <= pam_pls_idle;
					pls_r <= 1'b0;
				end
				else
				begin
					st_r <= st_nxt;
					pls_r <= (st_nxt == pam_pls_high);
				end
			end

			assign tmr_pulse[t] = pls_r;
		end
	endgenerate

	assign timer_zero_overflow_pulse_r = tmr_pulse[0];
	assign timer_one_overflow_pulse_r = tmr_pulse[1];

	////////////////////////////////////////////////////////////////
	// Function selection

	wire ifc_alt;
	wire [1:0] ifc_mode;
	wire [`PAM_ALT_LOW_BITS-1:0] alt_low;
	wire alt_cs;
	wire pam_pa4_fn_e pa4_fn;

	assign ifc_alt = interface_configuration[`PAM_IFC_ALT_BIT];
	assign ifc_mode = interface_configuration[`PAM_IFC_MODE_HI:`PAM_IFC_MODE_LO];

	// Bits 0 to 2 from own select bit and the interface bit
	genvar b;
	generate
		for (b = 0; b < `PAM_ALT_LOW_BITS; b = b + 1)
		begin : g_sel
			assign alt_low[b] = pam_alt_low(port_a_alt_select[b], ifc_alt);
		end
	endgenerate

	// Bit 3 from its select bit alone
	assign alt_cs = port_a_alt_select[3];

	// Bit 4 from both select bits and the mode field
	assign pa4_fn = port_a_alt_select[4] ? pam_pa4_fifo_wr
		: !port_a_alt_select_second[4] ? pam_pa4_port
		: (ifc_mode == `PAM_IFC_MODE_ENGINE) ? pam_pa4_ready
		: (ifc_mode == `PAM_IFC_MODE_SLAVE) ? pam_pa4_slave_wr
		: pam_pa4_port;

	////////////////////////////////////////////////////////////////
	// Alternate output values and pin next state

	wire [`PAM_PA_BITS-1:0] alt_on;
	wire [`PAM_PA_BITS-1:0] alt_val;
	wire [`PAM_PA_BITS-1:0] alt_drive;
	wire [`PAM_PA_BITS-1:0] pin_o_nxt;
	wire [`PAM_PA_BITS-1:0] pin_oe_nxt;

	assign alt_on[`PAM_ALT_LOW_BITS-1:0] = alt_low;
	assign alt_on[3] = alt_cs;
	assign alt_on[4] = (pa4_fn != pam_pa4_port);

	assign alt_val[0] = tmr_pulse[0];
	assign alt_val[1] = tmr_pulse[1];
	assign alt_val[2] = mem_output_enable_n;
	assign alt_val[3] = mem_chip_select_n;
	assign alt_val[4] = external_fifo_write_n;

	// Inputs of bit 4 leave the pin undriven
	assign alt_drive[3:0] = 4'hf;
	assign alt_drive[4] = (pa4_fn == pam_pa4_fifo_wr);

	// Port data where no alternate is chosen
	assign pin_o_nxt = (alt_on & alt_val) | (~alt_on & port_a_out);
	assign pin_oe_nxt = (alt_on & alt_drive) | (~alt_on & port_a_dir_out);

	////////////////////////////////////////////////////////////////
	// Pin drivers

	logic [`PAM_PA_BITS-1:0] pin_o_r;
	logic [`PAM_PA_BITS-1:0] pin_oe_r;

	// Registered so a selection change swaps cleanly on one edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_o_r <= '0;
			pin_oe_r <= '0;
		end
		else
		begin
			pin_o_r <= pin_o_nxt;
			pin_oe_r <= pin_oe_nxt;
		end
	end

	assign port_a_pin_o = pin_o_r;
	assign port_a_pin_oe = pin_oe_r;

	////////////////////////////////////////////////////////////////
	// Engine inputs on bit 4

	wire ready_nxt;
	wire slave_nxt;

	assign ready_nxt = (pa4_fn == pam_pa4_ready) & pin_s2_r[4];
	assign slave_nxt = (pa4_fn == pam_pa4_slave_wr) & pin_s2_r[4];

	// Zero while the mode is not chosen
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			engine_ready_input_four_r <= 1'b0;
			slave_fifo_write_strobe_r <= 1'b0;
		end
		else
		begin
			engine_ready_input_four_r <= ready_nxt;
			slave_fifo_write_strobe_r <= slave_nxt;
		end
	end
endmodule

// ### verif/pam_top_sva.sv
// Checker of the port A pins, clock pin and timer 0 pulse of pam_top.
// Assumes a bind into pam_top; it sees only that module's ports.
module pam_top_sva
(
	// Clock and reset
	input wire logic clk, nrst,
	// Settings and sources
	input wire pam_pkg::pam_byte_t processor_control_status, port_a_alt_select,
	input wire pam_pkg::pam_byte_t port_a_alt_select_second, interface_configuration,
	input wire logic [4:0] port_a_pin_i,
	input wire logic mem_output_enable_n, mem_chip_select_n, external_fifo_write_n,
	// Outputs watched
	input wire logic [4:0] port_a_pin_o, port_a_pin_oe,
	input wire logic processor_clock_pin_o, processor_clock_pin_oe,
	input wire logic proc_clock_level, proc_clock_rise,
	input wire logic proc_rate_fast_r, proc_clock_inverted_r,
	input wire logic engine_ready_input_four_r, timer_zero_overflow_pulse_r
);
	import pam_pkg::*;
	// Short views of settings and outputs
	wire pam_byte_t sel = port_a_alt_select;
	wire logic gate = interface_configuration[3];
	wire logic rdy_mode = !sel[4] && port_a_alt_select_second[4]
		&& interface_configuration[1:0] == 2'h2;
	wire logic inv = proc_clock_inverted_r;
	wire logic fast = proc_rate_fast_r;
	wire logic rise = proc_clock_rise;
	wire logic [4:0] oe = port_a_pin_oe;
	wire logic [4:0] po = port_a_pin_o;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	// Reset and clock pin
	rst_input_a: assert property (disable iff (1'b0)
		!nrst |-> {oe, processor_clock_pin_oe} == 6'h00) else $error("pin driven in reset");
	ck_float_a: assert property (
		1'b1 |=> processor_clock_pin_oe == !$past(processor_control_status[1]))
		else $error("clock pin enable");
	ck_polarity_a: assert property (
		processor_clock_pin_oe && inv == $past(inv) && inv == $past(inv, 2)
		|-> processor_clock_pin_o == (proc_clock_level ^ inv)) else $error("clock polarity");
	slow_gap_a: assert property (
		!fast && !$past(fast, 8) && rise ##1 !fast[*5]
		|-> !$past(rise, 4) && !$past(rise, 3) && !$past(rise, 2) && !$past(rise, 1) && !rise)
		else $error("slow clock too fast");
	fast_gap_a: assert property (
		fast && $past(fast, 8) && rise ##1 fast[*5]
		|-> !$past(rise, 4) && !$past(rise, 3) && ($past(rise, 2) || $past(rise, 1)))
		else $error("fast clock period");

	////////////////////////////////////////////////////////////////////////////////
	// Alternate functions
	cs_alt_a: assert property (
		sel[3] |=> oe[3] && po[3] == $past(mem_chip_select_n)) else $error("chip select pin");
	memoe_alt_a: assert property (
		sel[2] && !gate |=> oe[2] && po[2] == $past(mem_output_enable_n))
		else $error("output enable pin");
	fifo_alt_a: assert property (
		sel[4] |=> oe[4] && po[4] == $past(external_fifo_write_n)) else $error("fifo strobe pin");
	ready_in_a: assert property (
		rdy_mode[*4] |-> !oe[4] && engine_ready_input_four_r == $past(port_a_pin_i[4], 3))
		else $error("ready input");
	t0_width_a: assert property (
		timer_zero_overflow_pulse_r && rise |=> !timer_zero_overflow_pulse_r)
		else $error("timer pulse width");
endmodule

bind pam_top pam_top_sva u_sva
(
	.clk(clk),
	.nrst(nrst),
	.processor_control_status(processor_control_status),
	.port_a_alt_select(port_a_alt_select),
	.port_a_alt_select_second(port_a_alt_select_second),
	.interface_configuration(interface_configuration),
	.port_a_pin_i(port_a_pin_i),
	.mem_output_enable_n(mem_output_enable_n),
	.mem_chip_select_n(mem_chip_select_n),
	.external_fifo_write_n(external_fifo_write_n),
	.port_a_pin_o(port_a_pin_o),
	.port_a_pin_oe(port_a_pin_oe),
	.processor_clock_pin_o(processor_clock_pin_o),
	.processor_clock_pin_oe(processor_clock_pin_oe),
	.proc_clock_level(proc_clock_level),
	.proc_clock_rise(proc_clock_rise),
	.proc_rate_fast_r(proc_rate_fast_r),
	.proc_clock_inverted_r(proc_clock_inverted_r),
	.engine_ready_input_four_r(engine_ready_input_four_r),
	.timer_zero_overflow_pulse_r(timer_zero_overflow_pulse_r)
);

// ### verif/pam_board.sv
// Board model: crystal source, pull-ups and outside drivers on port A.
// Assumes the pin level and enable outputs of pam_top.
module pam_board
(
	// Pins from the block
	input wire logic [4:0] po,
	input wire logic [4:0] poe,
	// Outside drivers set by the bench
	input wire logic [4:0] een,
	input wire logic [4:0] evl,
	// Levels seen by the block
	output logic crystal_input,
	output logic [4:0] pi
);
	timeunit 1ns;
	timeprecision 1ps;
	// Free running 12 MHz reference
	initial
	begin
		crystal_input = 1'b0;
		forever #41.667 crystal_input = ~crystal_input;
	end
	// Wire level: block driver, else outside party, else pull-up
	assign pi = (poe & po) | (~poe & een & evl) | (~poe & ~een);
endmodule

// ### verif/pam_top_tb.sv
// Bench of pam_top: port use, alternate functions, clock pin and timers.
// Assumes pam_board on the pins and the checker bound to the block.
module pam_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pam_pkg::*;
	logic clk = 1'b0, nrst = 1'b1, boot_load_done = 1'b0, boot_memory_answered = 1'b0;
	pam_byte_t boot_configuration_byte = 8'h00, processor_control_status = 8'h00;
	pam_byte_t sel = 8'h00, sel2 = 8'h00, ifc = 8'h00;
	logic [4:0] pout = 5'h00, pdir = 5'h00, een = 5'h00, evl = 5'h00, pi, po, poe, pin_r;
	logic interface_clock_select = 1'b0, timer_zero_ovf_full = 1'b0, timer_zero_ovf_low = 1'b0;
	logic timer_one_ovf_full = 1'b0, timer_one_ovf_low = 1'b0, mem_output_enable_n = 1'b1;
	logic mem_chip_select_n = 1'b1, external_fifo_write_n = 1'b1;
	logic [1:0] timer_zero_mode = 2'h0, timer_one_mode = 2'h0;
	logic crystal_input, processor_clock_pin_o, processor_clock_pin_oe, proc_clock_level;
	logic proc_clock_rise, proc_rate_fast_r, proc_clock_inverted_r, engine_ready_input_four_r;
	logic slave_fifo_write_strobe_r, engine_clock_external_r, p0, p1;
	logic timer_zero_overflow_pulse_r, timer_one_overflow_pulse_r;
	logic [3:0] exp4 [4] = '{4'hc, 4'h2, 4'h1, 4'h8};
	int mismatches = 0, samples_checked = 0, n;

	pam_top DUT
	(
		.clk(clk),
		.nrst(nrst),
		.crystal_input(crystal_input),
		.boot_load_done(boot_load_done),
		.boot_memory_answered(boot_memory_answered),
		.boot_configuration_byte(boot_configuration_byte),
		.processor_control_status(processor_control_status),
		.port_a_alt_select(sel),
		.port_a_alt_select_second(sel2),
		.interface_configuration(ifc),
		.interface_clock_select(interface_clock_select),
		.port_a_out(pout),
		.port_a_dir_out(pdir),
		.timer_zero_ovf_full(timer_zero_ovf_full),
		.timer_zero_ovf_low(timer_zero_ovf_low),
		.timer_zero_mode(timer_zero_mode),
		.timer_one_ovf_full(timer_one_ovf_full),
		.timer_one_ovf_low(timer_one_ovf_low),
		.timer_one_mode(timer_one_mode),
		.mem_output_enable_n(mem_output_enable_n),
		.mem_chip_select_n(mem_chip_select_n),
		.external_fifo_write_n(external_fifo_write_n),
		.port_a_pin_i(pi),
		.port_a_pin_o(po),
		.port_a_pin_oe(poe),
		.processor_clock_pin_o(processor_clock_pin_o),
		.processor_clock_pin_oe(processor_clock_pin_oe),
		.proc_clock_level(proc_clock_level),
		.proc_clock_rise(proc_clock_rise),
		.proc_rate_fast_r(proc_rate_fast_r),
		.proc_clock_inverted_r(proc_clock_inverted_r),
		.port_a_in_r(pin_r),
		.engine_ready_input_four_r(engine_ready_input_four_r),
		.slave_fifo_write_strobe_r(slave_fifo_write_strobe_r),
		.engine_clock_external_r(engine_clock_external_r),
		.timer_zero_overflow_pulse_r(timer_zero_overflow_pulse_r),
		.timer_one_overflow_pulse_r(timer_one_overflow_pulse_r)
	);
	pam_board board
	(
		.po(po),
		.poe(poe),
		.een(een),
		.evl(evl),
		.crystal_input(crystal_input),
		.pi(pi)
	);

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task test_done;
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task boot(input logic a, input pam_byte_t b);
		boot_memory_answered = a;
		boot_configuration_byte = b;
		boot_load_done = 1'b1;
		step(1);
		boot_load_done = 1'b0;
		step(3);
	endtask
	// Count clock rises over 240 cycles
	task rises(input int want);
		n = 0;
		repeat (240)
		begin
			step(1);
			n += proc_clock_rise;
		end
		chk(n > want - 3 && n < want + 3, 16'h1);
	endtask
	task pol(input logic i);
		repeat (12)
		begin
			step(1);
			chk(processor_clock_pin_o ^ proc_clock_level, i);
		end
	endtask
	// Fire one overflow kind on both timers and measure the pulse
	task tmr(input logic [1:0] m, input logic low, input logic want);
		timer_zero_mode = m;
		timer_one_mode = m;
		{timer_zero_ovf_full, timer_one_ovf_full} = {2{~low}};
		{timer_zero_ovf_low, timer_one_ovf_low} = {2{low}};
		step(1);
		{timer_zero_ovf_full, timer_one_ovf_full, timer_zero_ovf_low, timer_one_ovf_low} = 4'h0;
		{n, p1, p0} = 0;
		repeat (30)
		begin
			step(1);
			n += timer_zero_overflow_pulse_r;
			chk(timer_one_overflow_pulse_r, timer_zero_overflow_pulse_r);
			chk(po[1:0], {p1, p0});
			{p1, p0} = {timer_one_overflow_pulse_r, timer_zero_overflow_pulse_r};
		end
		chk(n > 5 && n < 8, want);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		// Falling edge of reset so the block clears before the first clock
		#2;
		nrst = 1'b0;
		step(5);
		chk(poe, 5'h00);
		nrst = 1'b1;
		step(3);
		chk({pin_r, proc_rate_fast_r, proc_clock_inverted_r}, 7'h7c);
		rises(36);
		boot(1'b0, 8'h06);
		chk({proc_rate_fast_r, proc_clock_inverted_r}, 2'b00);
		pol(1'b0);
		boot(1'b1, 8'h06);
		chk({proc_rate_fast_r, proc_clock_inverted_r}, 2'b11);
		rises(72);
		pol(1'b1);
		processor_control_status = 8'h02;
		step(2);
		chk(processor_clock_pin_oe, 1'b0);
		processor_control_status = 8'h00;
		interface_clock_select = 1'b1;
		step(2);
		chk({processor_clock_pin_oe, engine_clock_external_r}, 2'b11);
		boot(1'b1, 8'h00);
		// Port use with a driven pin, a pulled pin and an outside low
		pout = 5'h0a;
		pdir = 5'h1a;
		een = 5'h01;
		step(4);
		chk({poe, po & poe, pin_r}, {5'h1a, 5'h0a, 5'h0e});
		mem_output_enable_n = 1'b0;
		mem_chip_select_n = 1'b0;
		for (int g = 0; g < 2; g++)
		begin
			ifc = {4'h0, g[0], 3'h0};
			sel = 8'h0f;
			step(2);
			chk({poe[3:0], po[3]}, g ? 5'h14 : 5'h1e);
			sel = 8'h00;
			step(1);
			chk(poe, pdir);
		end
		// Bit 4: FIFO strobe, ready, slave strobe, then port use
		external_fifo_write_n = 1'b1;
		een = 5'h10;
		evl = 5'h10;
		for (int m = 0; m < 4; m++)
		begin
			sel[4] = (m == 0);
			sel2[4] = (m != 0);
			ifc[1:0] = m == 1 ? 2'h2 : m == 2 ? 2'h3 : 2'h1;
			step(5);
			chk({poe[4], po[4] & poe[4], engine_ready_input_four_r, slave_fifo_write_strobe_r},
				exp4[m]);
		end
		sel = 8'h03;
		sel2 = 8'h00;
		ifc = 8'h00;
		tmr(2'h0, 1'b0, 1'b1);
		tmr(2'h3, 1'b1, 1'b1);
		tmr(2'h3, 1'b0, 1'b0);
		nrst = 1'b0;
		step(2);
		chk({poe, processor_clock_pin_oe}, 6'h00);
		nrst = 1'b1;
		step(3);
		test_done;
	end
endmodule
